// ---- design/test_pattern_run_control.sv ----
// pattern run control: AHB-Lite register bank, frame sequencer, video stream
module test_pattern_run_control
   import tpg_ctrl_pkg::*;
#(
   parameter logic [15:0] MAX_DIM    = 16'h0780,
   parameter bit          HAS_COLOUR = 1'b1,
   parameter bit          INTERLACED = 1'b0
) (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        ARST_N_I,
   // AHB-Lite slave
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic        HREADY_I,
   input  wire logic [31:0] HWDATA_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // video stream out
   output logic             VID_VALID_O,
   input  wire logic        VID_READY_I,
   output logic      [47:0] VID_DATA_O,
   output logic             VID_SOP_O,
   output logic             VID_EOP_O
);
   typedef enum logic [2:0] {S_IDLE, S_CTRL, S_PIX, S_GAP} seq_e;

   // register bank
   logic        wr_pend_q, wr_pend_d;
   logic [2:0]  wr_idx_q, wr_idx_d;
   logic        wr_ok_q, wr_ok_d;
   logic        run_q, run_d;
   logic [15:0] width_q, width_d, height_q, height_d;
   logic [15:0] col_q [3];
   logic [15:0] col_d [3];
   logic [31:0] rdata_q, rdata_d;
   logic        busy;
   logic        take;

   // frame sequencer
   seq_e        st_q, st_d;
   logic [15:0] fw_q, fw_d, fh_q, fh_d;
   logic [15:0] fc_q [3];
   logic [15:0] fc_d [3];
   logic [15:0] x_q, x_d, y_q, y_d;
   logic        field_q, field_d;
   logic [2:0]  hdr_q, hdr_d;
   logic        f_valid, f_ready, f_sop, f_eop;
   logic [47:0] f_data;
   logic [49:0] f_out;

   function automatic logic reg_present(input logic [2:0] idx);
      if (idx >= IDX_COL_FIRST && idx <= IDX_COL_THIRD) begin
         return HAS_COLOUR; // see R8
      end
      return idx < IDX_COL_FIRST;
   endfunction

   // a word that maps onto a register built into this instance
   function automatic logic addr_ok(input logic [31:0] addr);
      return (addr[31:5] == 27'h0) && reg_present(addr[4:2]);
   endfunction

   assign take = HSEL_I && HREADY_I && HTRANS_I[1];
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;
   assign HRDATA_O    = rdata_q;
   // a gap that ends the last field counts as between frames
   assign busy        = (st_q == S_CTRL) || (st_q == S_PIX) ||
                        (st_q == S_GAP && field_q); // see R2 see R3

   always_comb begin
      wr_pend_d = take && HWRITE_I;
      wr_idx_d  = HADDR_I[4:2];
      wr_ok_d   = addr_ok(HADDR_I);
      run_d     = run_q;
      width_d   = width_q;
      height_d  = height_q;
      col_d     = col_q;
      rdata_d   = rdata_q;
      if (wr_pend_q && wr_ok_q) begin
         unique case (wr_idx_q)
            IDX_RUN_CTRL:   run_d = HWDATA_I[RUN_BIT]; // see R1 see R13
            IDX_WIDTH:      width_d  = HWDATA_I[REG_W-1:0]; // see R12
            IDX_HEIGHT:     height_d = HWDATA_I[REG_W-1:0];
            IDX_COL_FIRST:  col_d[0] = HWDATA_I[REG_W-1:0]; // see R7
            IDX_COL_SECOND: col_d[1] = HWDATA_I[REG_W-1:0];
            IDX_COL_THIRD:  col_d[2] = HWDATA_I[REG_W-1:0];
            default: ; // status is read only
         endcase
      end
      if (take && !HWRITE_I) begin
         rdata_d = 32'h0000_0000;
         if (addr_ok(HADDR_I)) begin
            unique case (HADDR_I[4:2])
               IDX_RUN_CTRL:   rdata_d[RUN_BIT]  = run_q; // see R13
               IDX_RUN_STAT:   rdata_d[BUSY_BIT] = busy; // see R2 see R3
               IDX_WIDTH:      rdata_d[15:0] = width_q;
               IDX_HEIGHT:     rdata_d[15:0] = height_q;
               IDX_COL_FIRST:  rdata_d[15:0] = col_q[0];
               IDX_COL_SECOND: rdata_d[15:0] = col_q[1];
               IDX_COL_THIRD:  rdata_d[15:0] = col_q[2];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 3'h0;
         wr_ok_q   <= 1'b0;
         run_q     <= 1'b0;
         width_q   <= WIDTH_RST;
         height_q  <= HEIGHT_RST;
         col_q     <= '{COLOUR_RST, COLOUR_RST, COLOUR_RST};
         rdata_q   <= 32'h0000_0000;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_idx_q  <= wr_idx_d;
         wr_ok_q   <= wr_ok_d;
         run_q     <= run_d;
         width_q   <= width_d;
         height_q  <= height_d;
         col_q     <= col_d;
         rdata_q   <= rdata_d;
      end
   end

   // sequencer: header of 3 beats (width, height, field flag), then pixels
   always_comb begin
      st_d    = st_q;
      fw_d    = fw_q;
      fh_d    = fh_q;
      fc_d    = fc_q;
      x_d     = x_q;
      y_d     = y_q;
      field_d = field_q;
      hdr_d   = hdr_q;
      f_valid = 1'b0;
      f_sop   = 1'b0;
      f_eop   = 1'b0;
      f_data  = 48'h0000_0000_0000;
      unique case (st_q)
         S_IDLE, S_GAP: begin
            if (INTERLACED && field_q) begin
               st_d  = S_CTRL; // see R11
               hdr_d = 3'h0;
            end else if (run_q) begin
               fw_d  = width_q; // see R9 see R1
               fh_d  = height_q;
               fc_d  = col_q;
               st_d  = S_CTRL; // see R10
               hdr_d = 3'h0;
            end else begin
               st_d = S_IDLE;
            end
         end
         S_CTRL: begin
            f_valid = 1'b1;
            f_sop   = (hdr_q == 3'h0);
            f_eop   = (hdr_q == 3'h2);
            unique case (hdr_q)
               3'h0:    f_data = {28'h0, PKT_CTRL, fw_q}; // see R10
               3'h1:    f_data = {32'h0, INTERLACED ? fh_q >> 1 : fh_q};
               default: f_data = {46'h0, INTERLACED, field_q};
            endcase
            if (f_ready) begin
               hdr_d = hdr_q + 3'h1;
               if (hdr_q == 3'h2) begin
                  st_d = S_PIX;
                  x_d  = 16'h0000;
                  y_d  = 16'h0000;
               end
            end
         end
         S_PIX: begin
            f_valid = 1'b1;
            f_sop   = (x_q == 16'h0000) && (y_q == 16'h0000);
            f_eop   = (x_q == fw_q - 16'h0001) &&
                      (y_q == (INTERLACED ? (fh_q >> 1) : fh_q) - 16'h0001);
            f_data  = {fc_q[2], fc_q[1], fc_q[0]}; // see R7
            if (f_ready) begin
               if (x_q == fw_q - 16'h0001) begin // see R4
                  x_d = 16'h0000;
                  y_d = y_q + 16'h0001; // see R5
               end else begin
                  x_d = x_q + 16'h0001;
               end
               if (f_eop) begin
                  st_d    = S_GAP; // see R3
                  field_d = INTERLACED ? !field_q : 1'b0;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_q    <= S_IDLE;
         fw_q    <= WIDTH_RST;
         fh_q    <= HEIGHT_RST;
         fc_q    <= '{COLOUR_RST, COLOUR_RST, COLOUR_RST};
         x_q     <= 16'h0000;
         y_q     <= 16'h0000;
         field_q <= 1'b0;
         hdr_q   <= 3'h0;
      end else begin
         st_q    <= st_d;
         fw_q    <= fw_d;
         fh_q    <= fh_d;
         fc_q    <= fc_d;
         x_q     <= x_d;
         y_q     <= y_d;
         field_q <= field_d;
         hdr_q   <= hdr_d;
      end
   end

   stream_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk_i       (CLK_I),
      .arst_n_i    (ARST_N_I),
      .in_valid_i  (f_valid),
      .in_ready_o  (f_ready),
      .in_data_i   ({f_sop, f_eop, f_data}),
      .out_valid_o (VID_VALID_O),
      .out_ready_i (VID_READY_I),
      .out_data_o  (f_out)
   );
   assign VID_SOP_O  = f_out[49];
   assign VID_EOP_O  = f_out[48];
   assign VID_DATA_O = f_out[47:0];

   default clocking dc @(posedge CLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   idle_status_a: assert property (st_q == S_IDLE && // see R2
      take && !HWRITE_I && addr_ok(HADDR_I) &&
      HADDR_I[4:2] == IDX_RUN_STAT |=> !HRDATA_O[BUSY_BIT])
      else $error("status high between frames");
   gap_status_a: assert property (st_q == S_GAP && !field_q && // see R2
      !run_q |=> st_q == S_IDLE && !busy)
      else $error("status high after halted frame");
   busy_read_a: assert property (st_q == S_PIX && // see R3
      take && !HWRITE_I && addr_ok(HADDR_I) &&
      HADDR_I[4:2] == IDX_RUN_STAT |=> HRDATA_O[BUSY_BIT])
      else $error("status low while producing");
   halt_hold_a: assert property (!run_q && st_q == S_IDLE && // see R1
      !field_q |=> st_q == S_IDLE)
      else $error("generator left idle without run request");
   run_write_a: assert property (wr_pend_q && wr_ok_q && // see R1
      wr_idx_q == IDX_RUN_CTRL |=> run_q == $past(HWDATA_I[RUN_BIT]))
      else $error("run request not stored");
   no_abort_a: assert property (st_q == S_PIX && !f_eop |=> busy) // see R3
      else $error("frame aborted");
   sample_a: assert property (st_q == S_IDLE && run_q |=> // see R9
      fw_q == $past(width_q) && fh_q == $past(height_q))
      else $error("controls not sampled");
   sample_col_a: assert property (st_q == S_IDLE && run_q |=> // see R7
      fc_q[0] == $past(col_q[0]) && fc_q[2] == $past(col_q[2]))
      else $error("colour copy not sampled");
   hold_copy_a: assert property (st_q == S_PIX |=> $stable(fw_q)) // see R9
      else $error("width copy changed mid frame");
   ctrl_first_a: assert property ($rose(st_q == S_PIX) |-> // see R10
      $past(st_q) == S_CTRL)
      else $error("image without control packet");
   ctrl_head_a: assert property (st_q == S_CTRL && // see R10
      hdr_q == 3'h0 |-> f_sop && f_data[19:16] == PKT_CTRL)
      else $error("control packet header wrong");
   ctrl_len_a: assert property (st_q == S_CTRL && hdr_q == 3'h2 && // see R10
      f_ready |=> st_q == S_PIX)
      else $error("control packet length wrong");
   field_hold_a: assert property (st_q == S_GAP && field_q |=> // see R11
      st_q == S_CTRL && $stable(fw_q) && $stable(fh_q))
      else $error("controls resampled between fields");
   line_len_a: assert property (st_q == S_PIX && f_ready && // see R4
      x_q == fw_q - 16'h0001 |=> x_q == 16'h0000)
      else $error("line length wrong");
   rows_a: assert property (st_q == S_PIX |-> y_q < fh_q) // see R5
      else $error("frame taller than height");
   colour_a: assert property (st_q == S_PIX |-> // see R7
      f_data == {fc_q[2], fc_q[1], fc_q[0]})
      else $error("colour component wrong");
   upper_zero_a: assert property (take && !HWRITE_I |=> // see R12
      HRDATA_O[31:16] == 16'h0000)
      else $error("read data wider than register");
   unused_a: assert property (take && !HWRITE_I && // see R13
      HADDR_I[4:2] <= IDX_RUN_STAT |=> HRDATA_O[15:1] == 15'h0000)
      else $error("unused control bits read back");

   // scenarios the bench should reach
   ctrl_cov: cover property (st_q == S_CTRL ##1 st_q == S_CTRL);
   frame_cov: cover property (st_q == S_PIX && f_eop && f_ready);
   stall_cov: cover property (!f_ready && st_q == S_PIX);
   halt_cov: cover property (st_q == S_GAP ##1 st_q == S_IDLE);
   status_cov: cover property (take && !HWRITE_I && busy);
endmodule

// ---- design/tpg_ctrl_pkg.sv ----
// package: register map, field layout and constants of the pattern run control
// Summary of operation
// R1 - control bit 0 requests running; other bits do nothing; a cleared bit halts the generator before it next samples its controls.
// R2 - status bit 0 at offset 1 reads zero in the gap between frames.
// R3 - status bit 0 reads one while a frame is produced, and the frame in progress cannot be halted.
// R4 - the register at offset 2 sets the pixels per line, and lines are that long.
// R5 - the register at offset 3 sets the progressive line count, and frames or fields are sized from it.
// R6 - software programs width and height only between 32 and the configured maximum.
// R7 - a uniform background takes its three colour components from offsets 4, 5 and 6.
// R8 - the three colour registers exist only with a uniform background and run-time control enabled.
// R9 - the controls are sampled once at frame start into private copies, so mid-frame writes apply next frame.
// R10 - after sampling, a control packet describing the image packet is sent before that image packet.
// R11 - for interlaced output, controls are sampled only before the first field, yet a control packet precedes every field.
// R12 - every register in the map is 16 bits wide.
// R13 - unused bits of control and status ignore writes and read as zero.
package tpg_ctrl_pkg;
   localparam int unsigned REG_W          = 16;
   localparam logic [2:0]  IDX_RUN_CTRL   = 3'h0;
   localparam logic [2:0]  IDX_RUN_STAT   = 3'h1;
   localparam logic [2:0]  IDX_WIDTH      = 3'h2;
   localparam logic [2:0]  IDX_HEIGHT     = 3'h3;
   localparam logic [2:0]  IDX_COL_FIRST  = 3'h4;
   localparam logic [2:0]  IDX_COL_SECOND = 3'h5;
   localparam logic [2:0]  IDX_COL_THIRD  = 3'h6;
   localparam int unsigned RUN_BIT        = 0;
   localparam int unsigned BUSY_BIT       = 0;
   localparam logic [15:0] WIDTH_RST      = 16'h0020;
   localparam logic [15:0] HEIGHT_RST     = 16'h0020;
   localparam logic [15:0] COLOUR_RST     = 16'h0000;
   localparam logic [15:0] DIM_MIN        = 16'h0020;
   localparam int unsigned FIFO_W         = 50;
   localparam int unsigned FIFO_D         = 32;
   localparam logic [3:0]  PKT_CTRL       = 4'hF;
   localparam logic [3:0]  PKT_IMAGE      = 4'h0;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  HSIZE_WORD     = 2'h2;
endpackage

// ---- design/stream_fifo.sv ----
// synchronous valid/ready FIFO with parameter width and depth
module stream_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready_o  = (cnt_q < (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];

   always_comb begin
      push  = in_valid_i && in_ready_o;
      pop   = out_valid_o && out_ready_i;
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   full_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cnt_q == (AW+1)'(DEPTH) |-> !in_ready_o)
      else $error("fifo accepts while full");
endmodule

// ---- verif/video_sink_model.sv ----
// downstream video sink model: takes beats, stalls every other cycle on request
module video_sink_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // stream in
   input  wire logic        valid_i,
   output logic             ready_o,
   input  wire logic [47:0] data_i,
   input  wire logic        sop_i,
   input  wire logic        eop_i,
   // stall control
   input  wire logic        slow_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [49:0] beats[$];
   logic        phase_q;
   assign ready_o = slow_i ? phase_q : 1'b1;
   // each taken beat is kept as {sop, eop, data}
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase_q <= 1'b0;
         beats.delete();
      end else begin
         phase_q <= ~phase_q;
         if (valid_i && ready_o) beats.push_back({sop_i, eop_i, data_i});
      end
   end
endmodule

// ---- verif/tb_test_pattern_run_control.sv ----
// testbench: register access over the bus and frame checks at the sink
module tb_test_pattern_run_control;
   timeunit 1ns;
   timeprecision 100ps;
   import tpg_ctrl_pkg::*;
   logic        clk, arst_n, hsel, hwrite, slow;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hready, hresp, vvalid, vready, vsop, veop;
   logic [47:0] vdata;
   int          n_errors, n_checks, cycles;

   test_pattern_run_control uut (.CLK_I(clk), .ARST_N_I(arst_n),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(hsize), .HREADY_I(hready), .HWDATA_I(hwdata),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .VID_VALID_O(vvalid), .VID_READY_I(vready), .VID_DATA_O(vdata),
      .VID_SOP_O(vsop), .VID_EOP_O(veop));
   video_sink_model sink (.clk_i(clk), .arst_n_i(arst_n), .valid_i(vvalid),
      .ready_o(vready), .data_i(vdata), .sop_i(vsop), .eop_i(veop),
      .slow_i(slow));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // hang guard: the run needs well under ten thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [31:0] ba(input logic [2:0] idx);
      return {27'h0, idx, 2'b00};
   endfunction

   // one single word transfer; address phase held until hready is seen
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= {1'b0, HSIZE_WORD};
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk(48'(hresp), 48'h0, "response");
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      logic [31:0] r;
      xfer(1'b1, a, {16'h0, d}, r);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(48'(r), 48'(exp), "register read");
   endtask

   task automatic wait_beats(input int n);
      while (sink.beats.size() < n) @(posedge clk);
   endtask

   task automatic check_frame(input logic [15:0] w, input logic [15:0] h,
                              input logic [47:0] px);
      int          n;
      logic [49:0] b;
      n = int'(w) * int'(h);
      wait_beats(n + 3);
      b = sink.beats.pop_front();
      chk(48'(b[49:48]), 48'h2, "ctrl first flags");
      chk(48'(b[15:0]), 48'(w), "ctrl width");
      b = sink.beats.pop_front();
      chk(48'(b[49:48]), 48'h0, "ctrl mid flags");
      chk(48'(b[15:0]), 48'(h), "ctrl height");
      b = sink.beats.pop_front();
      chk(48'(b[49:48]), 48'h1, "ctrl last flags");
      for (int i = 0; i < n; i++) begin
         b = sink.beats.pop_front();
         chk(b[47:0], px, "pixel");
         chk(48'(b[49:48]), 48'({i == 0, i == n - 1}), "pixel flags");
      end
   endtask

   task automatic check_halt();
      repeat (100) @(posedge clk);
      chk(48'(sink.beats.size()), 48'h0, "beats after halt");
      rd_chk(ba(IDX_RUN_STAT), 16'h0000);
   endtask

   initial begin
      {hsel, hwrite, slow} = '0;
      {haddr, hwdata, htrans, hsize} = '0;
      arst_n = 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd_chk(ba(IDX_RUN_CTRL), 16'h0000);
      rd_chk(ba(IDX_RUN_STAT), 16'h0000);
      rd_chk(ba(IDX_WIDTH), WIDTH_RST);
      rd_chk(ba(IDX_HEIGHT), HEIGHT_RST);
      rd_chk(ba(IDX_COL_FIRST), COLOUR_RST);
      wr(32'h0000_001C, 16'hBEEF);
      rd_chk(32'h0000_001C, 16'h0000);
      wr(ba(IDX_RUN_STAT), 16'hFFFF);
      rd_chk(ba(IDX_RUN_STAT), 16'h0000);
      wr(ba(IDX_WIDTH), 16'h0021);
      wr(ba(IDX_COL_FIRST), 16'h1234);
      wr(ba(IDX_COL_SECOND), 16'h5678);
      wr(ba(IDX_COL_THIRD), 16'h9ABC);
      rd_chk(ba(IDX_COL_THIRD), 16'h9ABC);
      wr(ba(IDX_RUN_CTRL), 16'hFFFF);
      rd_chk(ba(IDX_RUN_CTRL), 16'h0001);
      wait_beats(3);
      rd_chk(ba(IDX_RUN_STAT), 16'h0001);
      wr(ba(IDX_WIDTH), 16'h0040);
      wr(ba(IDX_COL_FIRST), 16'hFEDC);
      wr(ba(IDX_RUN_CTRL), 16'h0000);
      rd_chk(ba(IDX_RUN_STAT), 16'h0001);
      check_frame(16'h0021, 16'h0020, 48'h9ABC_5678_1234);
      check_halt();
      slow <= 1'b1;
      wr(ba(IDX_RUN_CTRL), 16'h0001);
      wait_beats(3);
      wr(ba(IDX_RUN_CTRL), 16'h0000);
      check_frame(16'h0040, 16'h0020, 48'h9ABC_5678_FEDC);
      check_halt();
      report_and_stop();
   end
endmodule
